// file: src/ebp_pkg.sv
/*
 * Package for the external bus port pin block: timing constants, bus cycle
 * kinds, and the packed carriers used between the core side and the pins.
 * Assumes a 10 MHz reference clock that stands in for the crystal.
 */
package ebp_pkg;
   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned CLK_PERIOD_NS = 100;          // Reference clock period
   localparam int unsigned XTAL_PER_MC = 12;             // Crystal clocks per machine cycle
   localparam int unsigned STATES_PER_MC = 6;            // Two clocks per state
   localparam logic [3:0] MC_LAST = 4'hb;                // Last phase of a machine cycle
   localparam logic [3:0] ALE_PH0 = 4'h0;                // First latch strobe phase
   localparam logic [3:0] ALE_PH1 = 4'h6;                // Second latch strobe phase
   localparam logic [3:0] PS_PH0 = 4'h2;                 // First store strobe start
   localparam logic [3:0] PS_PH1 = 4'h8;                 // Second store strobe start
   localparam int unsigned PS_LEN = 3;                   // Store strobe low phases
   localparam int unsigned HOST_MC = 20;                 // Reset high machine cycles before entry
   localparam logic [4:0] HOST_CNT_MAX = 5'h15;          // Counter saturates above HOST_MC
   localparam logic [3:0] DM_PH = 4'h2;                  // Data strobe start phase
   localparam logic [3:0] DM_END = 4'ha;                 // Data strobe end phase
   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [7:0] PORT_RST = 8'hff;              // Port latches after reset
   // ==========================================================================
   // Multifunction port bit positions
   // ==========================================================================
   localparam int unsigned MF_RXD = 0;
   localparam int unsigned MF_TXD = 1;
   localparam int unsigned MF_IRQ0 = 2;
   localparam int unsigned MF_IRQ1 = 3;
   localparam int unsigned MF_CNT0 = 4;
   localparam int unsigned MF_CNT1 = 5;
   localparam int unsigned MF_WR = 6;
   localparam int unsigned MF_RD = 7;

   // Kind of data access requested for a machine cycle
   typedef enum logic [1:0] {
      EBP_DM_NONE = 2'b00,
      EBP_DM_READ = 2'b01,
      EBP_DM_WRITE = 2'b10
   } ebp_dm_t;

   // Core request sampled at the start of each machine cycle
   typedef struct packed {
      logic ext_fetch;         // Executing from external program memory
      ebp_dm_t dm_kind;        // Data access this cycle
      logic dm_wide;           // Access uses the data pointer (16-bit address)
      logic [7:0] addr_hi;     // Upper address byte
   } ebp_req_t;

   // Alternate function outputs from peripherals
   typedef struct packed {
      logic txd;               // Serial transmit output
   } ebp_alt_out_t;

   // Alternate function inputs to peripherals, already synchronised
   typedef struct packed {
      logic rxd;
      logic ext_irq_zero_n;
      logic ext_irq_one_n;
      logic timer_zero_count_in;
      logic timer_one_count_in;
   } ebp_alt_in_t;
endpackage : ebp_pkg

// file: src/ebp_port_pins.sv
/*
 * External bus port pins: high-address port, multifunction port and the
 * program-store and address-latch strobes, paced in machine cycles.
 * Assumes the core updates its request once per machine cycle and that the
 * pads resolve the pull-up level when the active-low output enable is high.
 */
`timescale 1ns/1ns
`default_nettype none
// Contract
// RQ1: High-address port latch, pulled high, readable input
// RQ2: High-address port drives upper address on access
// RQ3: Multifunction port latch with pull-ups, readable
// RQ4: Bit 0 receive input, bit 1 transmit
// RQ5: Bits 2,3 external low interrupt requests
// RQ6: Bits 4,5 timer count inputs
// RQ7: Bits 6,7 low write and read strobes
// RQ8: Store strobe high during internal execution
// RQ9: Two store strobes per cycle, skip on data
// RQ10: Store strobe fall under long reset enters host
// RQ11: Host drives control on both ports
// RQ12: Store strobe enables external code read
// RQ13: Reset held high two machine cycles
// RQ14: Latch strobe one sixth rate, skip, disable
// RQ15: Alternate function bits keep latch one
module ebp_port_pins (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Device reset pin, active high, asynchronous to the clock
   input wire logic rst_pin_i,
   // Core side
   input var ebp_pkg::ebp_req_t req_i,
   input wire logic hi_latch_we_i,
   input wire logic [7:0] hi_latch_d_i,
   input wire logic mf_latch_we_i,
   input wire logic [7:0] mf_latch_d_i,
   input wire logic latch_strobe_off_i,
   input var ebp_pkg::ebp_alt_out_t alt_out_i,
   output var ebp_pkg::ebp_alt_in_t alt_in_o,
   output logic [7:0] hi_pins_rd_o,
   output logic [7:0] mf_pins_rd_o,
   output logic mc_start_o,
   output logic host_mode_o,
   // High-address port pads
   input wire logic [7:0] high_address_port_i,
   output logic [7:0] high_address_port_o,
   output logic [7:0] high_address_port_oe_n_o,
   // Multifunction port pads
   input wire logic [7:0] multifunction_port_i,
   output logic [7:0] multifunction_port_o,
   output logic [7:0] multifunction_port_oe_n_o,
   // Program-store strobe pad
   input wire logic program_store_strobe_n_i,
   output logic program_store_strobe_n_o,
   output logic program_store_strobe_oe_n_o,
   // Address latch strobe
   output logic addr_latch_o
);
   // ==========================================================================
   // Machine cycle phase counter
   // ==========================================================================
   logic [3:0] phase_ff;            // Clock phase within a machine cycle
   ebp_pkg::ebp_req_t cur_ff;       // Request of the current machine cycle
   logic rst_s1_ff, rst_sync_ff;    // Reset pin sync stages
   logic host_mode_ff;              // External host programming mode

   // Phase wraps every twelve clocks
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || rst_sync_ff) begin
         phase_ff <= 4'h0;
      end else if (phase_ff == ebp_pkg::MC_LAST) begin
         phase_ff <= 4'h0;
      end else begin
         phase_ff <= phase_ff + 4'h1;
      end
   end

   assign mc_start_o = (phase_ff == ebp_pkg::MC_LAST);

   // Request captured at the cycle boundary
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || rst_sync_ff) begin
         cur_ff <= '0;
      end else if (mc_start_o) begin
         cur_ff <= req_i;
      end
   end

   // ==========================================================================
   // Synchronisers for pad inputs
   // ==========================================================================
   logic [7:0] hi_s1_ff, hi_s2_ff;      // High-address port sync stages
   logic [7:0] mf_s1_ff, mf_s2_ff;      // Multifunction port sync stages
   logic ps_s1_ff, ps_s2_ff, ps_s3_ff;  // Store strobe sync and history

   // Two flops on every asynchronous pad input
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         hi_s1_ff <= 8'hff;
         hi_s2_ff <= 8'hff;
         mf_s1_ff <= 8'hff;
         mf_s2_ff <= 8'hff;
         ps_s1_ff <= 1'b1;
         ps_s2_ff <= 1'b1;
         ps_s3_ff <= 1'b1;
         rst_s1_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         hi_s1_ff <= high_address_port_i;
         hi_s2_ff <= hi_s1_ff;
         mf_s1_ff <= multifunction_port_i;
         mf_s2_ff <= mf_s1_ff;
         ps_s1_ff <= program_store_strobe_n_i;
         ps_s2_ff <= ps_s1_ff;
         ps_s3_ff <= ps_s2_ff;
         rst_s1_ff <= rst_pin_i;
         rst_sync_ff <= rst_s1_ff;
      end
   end

   // Pin levels as read by software
   assign hi_pins_rd_o = hi_s2_ff; // RQ1
   assign mf_pins_rd_o = mf_s2_ff; // RQ3

   // Alternate inputs taken from the synchronised pins
   assign alt_in_o.rxd = mf_s2_ff[ebp_pkg::MF_RXD]; // RQ4
   assign alt_in_o.ext_irq_zero_n = mf_s2_ff[ebp_pkg::MF_IRQ0]; // RQ5
   assign alt_in_o.ext_irq_one_n = mf_s2_ff[ebp_pkg::MF_IRQ1]; // RQ5
   assign alt_in_o.timer_zero_count_in = mf_s2_ff[ebp_pkg::MF_CNT0]; // RQ6
   assign alt_in_o.timer_one_count_in = mf_s2_ff[ebp_pkg::MF_CNT1]; // RQ6

   // ==========================================================================
   // Port latches
   // ==========================================================================
   logic [7:0] hi_latch_ff;   // High-address port latch
   logic [7:0] mf_latch_ff;   // Multifunction port latch

   // Latches reset to ones so the pins start as pulled-up inputs
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || rst_sync_ff) begin
         hi_latch_ff <= ebp_pkg::PORT_RST; // RQ1
         mf_latch_ff <= ebp_pkg::PORT_RST; // RQ3
      end else begin
         if (hi_latch_we_i) begin
            hi_latch_ff <= hi_latch_d_i;
         end
         if (mf_latch_we_i) begin
            mf_latch_ff <= mf_latch_d_i;
         end
      end
   end

   // ==========================================================================
   // Strobe generation
   // ==========================================================================
   // Phase lies in [start, start+len)
   function automatic logic in_win(input logic [3:0] ph, input logic [3:0] start);
      in_win = (ph >= start) && (ph < start + 4'(ebp_pkg::PS_LEN));
   endfunction

   logic dm_active;       // Data access in this cycle
   logic nxt_ps_n;        // Next store strobe level
   logic nxt_ale;         // Next latch strobe level
   logic nxt_wr_n;        // Next write strobe level
   logic nxt_rd_n;        // Next read strobe level
   logic addr_drive;      // Upper address byte on the port
   logic ps_n_ff, ale_ff, wr_n_ff, rd_n_ff, addr_drive_ff;

   assign dm_active = (cur_ff.dm_kind != ebp_pkg::EBP_DM_NONE);

   // Combinational strobe decode from phase and cycle kind
   always_comb begin
      nxt_ps_n = 1'b1;
      nxt_ale = 1'b0;
      nxt_wr_n = 1'b1;
      nxt_rd_n = 1'b1;
      addr_drive = 1'b0;
      if (!host_mode_ff) begin
         // Two store strobes per cycle, second dropped on data access
         if (cur_ff.ext_fetch) begin
            if (in_win(phase_ff, ebp_pkg::PS_PH0)) begin
               nxt_ps_n = 1'b0; // RQ9 RQ12
            end else if (in_win(phase_ff, ebp_pkg::PS_PH1) && !dm_active) begin
               nxt_ps_n = 1'b0; // RQ9
            end
            addr_drive = 1'b1; // RQ2
         end
         // Latch strobe at one sixth rate, second dropped on data access
         if (!latch_strobe_off_i) begin
            if (phase_ff == ebp_pkg::ALE_PH0) begin
               nxt_ale = 1'b1; // RQ14
            end else if (phase_ff == ebp_pkg::ALE_PH1 && !dm_active) begin
               nxt_ale = 1'b1; // RQ14
            end
         end
         // Data strobes over phases 2 to 9 of the cycle
         if (dm_active && phase_ff >= ebp_pkg::DM_PH && phase_ff < ebp_pkg::DM_END) begin
            nxt_wr_n = (cur_ff.dm_kind != ebp_pkg::EBP_DM_WRITE); // RQ7
            nxt_rd_n = (cur_ff.dm_kind != ebp_pkg::EBP_DM_READ); // RQ7
         end
         if (dm_active && cur_ff.dm_wide) begin
            addr_drive = 1'b1; // RQ2
         end
      end
   end

   // Registered strobes so pad outputs come from flops
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || rst_sync_ff) begin
         ps_n_ff <= 1'b1;
         ale_ff <= 1'b0;
         wr_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         addr_drive_ff <= 1'b0;
      end else begin
         ps_n_ff <= nxt_ps_n; // RQ8
         ale_ff <= nxt_ale;
         wr_n_ff <= nxt_wr_n;
         rd_n_ff <= nxt_rd_n;
         addr_drive_ff <= addr_drive;
      end
   end

   // ==========================================================================
   // Host mode entry
   // ==========================================================================
   logic [4:0] rst_mc_ff;     // Machine cycles with reset pin high
   logic [3:0] rst_ph_ff;     // Phase count while reset pin high

   // Counts reset-high machine cycles; saturates above the entry threshold
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || !rst_sync_ff) begin
         rst_mc_ff <= 5'h00;
         rst_ph_ff <= 4'h0;
      end else if (rst_ph_ff == ebp_pkg::MC_LAST) begin
         rst_ph_ff <= 4'h0;
         if (rst_mc_ff != ebp_pkg::HOST_CNT_MAX) begin
            rst_mc_ff <= rst_mc_ff + 5'h01;
         end
      end else begin
         rst_ph_ff <= rst_ph_ff + 4'h1;
      end
   end

   // Falling strobe edge after more than twenty cycles in reset
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         host_mode_ff <= 1'b0;
      end else if (rst_sync_ff && rst_mc_ff == ebp_pkg::HOST_CNT_MAX
                   && ps_s3_ff && !ps_s2_ff) begin
         host_mode_ff <= 1'b1; // RQ10
      end
   end

   assign host_mode_o = host_mode_ff;

   // ==========================================================================
   // Pad drive
   // ==========================================================================
   // In host mode and reset the ports release so the host can drive them
   always_comb begin
      high_address_port_o = hi_latch_ff;
      high_address_port_oe_n_o = hi_latch_ff; // RQ1
      multifunction_port_o = mf_latch_ff;
      // Alternate outputs gated with latch, which software keeps at one
      multifunction_port_o[ebp_pkg::MF_TXD] = mf_latch_ff[ebp_pkg::MF_TXD] & alt_out_i.txd; // RQ4 RQ15
      multifunction_port_o[ebp_pkg::MF_WR] = mf_latch_ff[ebp_pkg::MF_WR] & wr_n_ff; // RQ7 RQ15
      multifunction_port_o[ebp_pkg::MF_RD] = mf_latch_ff[ebp_pkg::MF_RD] & rd_n_ff; // RQ7 RQ15
      multifunction_port_oe_n_o = multifunction_port_o; // RQ3
      if (addr_drive_ff) begin
         high_address_port_o = cur_ff.addr_hi; // RQ2
         high_address_port_oe_n_o = 8'h00;
      end
      if (host_mode_ff || rst_sync_ff) begin
         high_address_port_oe_n_o = 8'hff; // RQ11
         multifunction_port_oe_n_o = 8'hff; // RQ11
      end
   end

   assign program_store_strobe_n_o = ps_n_ff;
   // Store strobe pad released in reset so a host may pull it low
   assign program_store_strobe_oe_n_o = rst_sync_ff | host_mode_ff; // RQ10
   assign addr_latch_o = ale_ff;

   // ==========================================================================
   // Checks
   // ==========================================================================
   int unsigned ps_lows;      // Store strobe falls in the current machine cycle
   // Count strobe falls, cleared at reset and at each cycle boundary
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || mc_start_o) begin
         ps_lows <= 0;
      end else if (ps_n_ff && !nxt_ps_n) begin
         ps_lows <= ps_lows + 1;
      end
   end

   chk_ps_internal_high: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ8
      !cur_ff.ext_fetch && !$past(rst_sync_ff) |=> program_store_strobe_n_o)
      else $error("Store strobe low during internal execution");
   chk_ps_two_pulses: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i || rst_sync_ff) // RQ9
      mc_start_o && cur_ff.ext_fetch && !dm_active && !host_mode_ff && $past(cur_ff) == cur_ff
      |-> ps_lows == 2)
      else $error("Store strobe not twice per machine cycle");
   chk_ale_skip: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i || rst_sync_ff) // RQ14
      phase_ff == ebp_pkg::ALE_PH1 && dm_active |=> !addr_latch_o)
      else $error("Latch strobe not skipped on data access");
   // Latch strobe high for one clock, then low again
   sequence s_ale_pulse;
      addr_latch_o ##1 !addr_latch_o;
   endsequence
   chk_ale_rate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i || rst_sync_ff) // RQ14
      phase_ff == ebp_pkg::ALE_PH0 && !latch_strobe_off_i && !host_mode_ff |=> s_ale_pulse)
      else $error("Latch strobe missing at cycle start");
   chk_ale_off: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ14
      latch_strobe_off_i |=> !addr_latch_o)
      else $error("Latch strobe while disabled");
   chk_addr_drive: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ2
      addr_drive_ff && !host_mode_ff && !rst_sync_ff |-> high_address_port_oe_n_o == 8'h00
      && high_address_port_o == cur_ff.addr_hi)
      else $error("Upper address not driven");
   chk_host_entry: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ10
      rst_sync_ff && rst_mc_ff < ebp_pkg::HOST_CNT_MAX |=> !$rose(host_mode_ff))
      else $error("Host mode entered too early");
   chk_wr_strobe: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ7
      !wr_n_ff |-> !rd_n_ff == 1'b0)
      else $error("Write and read strobes together");
   chk_latch_reset: assert property (@(posedge ref_clk_i) // RQ1
      !reset_n_i |=> hi_latch_ff == ebp_pkg::PORT_RST && mf_latch_ff == ebp_pkg::PORT_RST)
      else $error("Port latches not ones after reset");
endmodule // ebp_port_pins
`default_nettype wire

// file: verification/ebp_mem_model.sv
/*
 * Far-side model for the port pins: external memory and logic on the pads.
 * Assumes pull-ups on every pad and that the bench asks for any external drive.
 */
`timescale 1ns/1ns
`default_nettype none
module ebp_mem_model (
   // Device pad outputs
   input wire logic [7:0] hi_o_i,
   input wire logic [7:0] hi_oe_n_i,
   input wire logic [7:0] mf_o_i,
   input wire logic [7:0] mf_oe_n_i,
   input wire logic ps_o_i,
   input wire logic ps_oe_n_i,
   // External drive requests, one bit pulls a pin low
   input wire logic [7:0] hi_low_i,
   input wire logic [7:0] mf_low_i,
   input wire logic ps_force_i,
   // Resolved pad levels
   output logic [7:0] hi_pin_o,
   output logic [7:0] mf_pin_o,
   output logic ps_pin_o
);
   // ==========================================================================
   // Pad resolution
   // ==========================================================================
   // A released pin goes to its pull-up unless the far side pulls it low
   always_comb begin
      hi_pin_o = (~hi_oe_n_i & hi_o_i) | (hi_oe_n_i & ~hi_low_i);
      mf_pin_o = (~mf_oe_n_i & mf_o_i) | (mf_oe_n_i & ~mf_low_i);
      // Strobe pad: forced low only while the device has released it
      ps_pin_o = ps_oe_n_i ? ~ps_force_i : ps_o_i;
   end
endmodule // ebp_mem_model
`default_nettype wire

// file: verification/ebp_port_pins_tb.sv
/*
 * Self-checking bench for the port pin block, one task per scenario.
 * Assumes the memory model resolves all pads and the package timing values.
 */
`timescale 1ns/1ns
`default_nettype none
module ebp_port_pins_tb;
   // ==========================================================================
   // Signals
   // ==========================================================================
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic rst_pin_i = 1'b0;
   ebp_pkg::ebp_req_t req_i = '0;
   logic hi_we = 1'b0;
   logic [7:0] hi_d = 8'hff;
   logic mf_we = 1'b0;
   logic [7:0] mf_d = 8'hff;
   logic ale_off = 1'b0;
   ebp_pkg::ebp_alt_out_t alt_out = '1;
   ebp_pkg::ebp_alt_in_t alt_in;
   logic [7:0] hi_rd, mf_rd, hi_o, hi_oe_n, mf_o, mf_oe_n, hi_pin, mf_pin;
   logic mc_start_o, host_mode_o, ps_o, ps_oe_n, ps_pin, ale;
   logic [7:0] hi_low = 8'h00;
   logic [7:0] mf_low = 8'h00;
   logic ps_force = 1'b0;
   int n_fail = 0;
   int compares = 0;
   // Clock: half period of 50 ns
   always #50 ref_clk_i = ~ref_clk_i;
   ebp_port_pins u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .rst_pin_i(rst_pin_i), .req_i(req_i),
      .hi_latch_we_i(hi_we), .hi_latch_d_i(hi_d), .mf_latch_we_i(mf_we), .mf_latch_d_i(mf_d),
      .latch_strobe_off_i(ale_off), .alt_out_i(alt_out), .alt_in_o(alt_in), .hi_pins_rd_o(hi_rd),
      .mf_pins_rd_o(mf_rd), .mc_start_o(mc_start_o), .host_mode_o(host_mode_o), .high_address_port_i(hi_pin),
      .high_address_port_o(hi_o), .high_address_port_oe_n_o(hi_oe_n), .multifunction_port_i(mf_pin),
      .multifunction_port_o(mf_o), .multifunction_port_oe_n_o(mf_oe_n), .program_store_strobe_n_i(ps_pin),
      .program_store_strobe_n_o(ps_o), .program_store_strobe_oe_n_o(ps_oe_n), .addr_latch_o(ale));
   ebp_mem_model u_mem (.hi_o_i(hi_o), .hi_oe_n_i(hi_oe_n), .mf_o_i(mf_o), .mf_oe_n_i(mf_oe_n), .ps_o_i(ps_o),
      .ps_oe_n_i(ps_oe_n), .hi_low_i(hi_low), .mf_low_i(mf_low), .ps_force_i(ps_force), .hi_pin_o(hi_pin),
      .mf_pin_o(mf_pin), .ps_pin_o(ps_pin));
   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   // Closing report, the single end of the run
   task automatic give_verdict();
      if (n_fail == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One comparison with mismatch report
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("[ERR] %s exp %h got %h", what, exp, got);
         n_fail++;
      end
   endtask
   // New request, then let two machine cycles settle
   task automatic set_req(input logic f, input ebp_pkg::ebp_dm_t k, input logic w, input logic [7:0] a);
      int i;
      @(negedge ref_clk_i);
      req_i = '{ext_fetch: f, dm_kind: k, dm_wide: w, addr_hi: a};
      for (i = 0; i < 24 && mc_start_o !== 1'b1; i++) @(negedge ref_clk_i);
      check("mc_start", 8'h01, {7'h0, mc_start_o});
      if (mc_start_o !== 1'b1) give_verdict();
      repeat (24) @(negedge ref_clk_i);
   endtask
   // Count strobe activity over two machine cycles
   task automatic window(output logic [7:0] ps, output logic [7:0] al, output logic [7:0] rd, output logic [7:0] wr);
      ps = 8'h00;
      al = 8'h00;
      rd = 8'h00;
      wr = 8'h00;
      repeat (24) begin
         @(negedge ref_clk_i);
         ps = ps + {7'h0, ~ps_pin};
         al = al + {7'h0, ale};
         rd = rd + {7'h0, ~mf_pin[7]};
         wr = wr + {7'h0, ~mf_pin[6]};
      end
   endtask
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   // Idle state after reset: ports released, strobe high
   task automatic t_reset();
      check("hi_oe_n", 8'hff, hi_oe_n);
      check("mf_pin", 8'hff, mf_pin);
      check("ps_pin", 8'h01, {7'h0, ps_pin});
      check("host", 8'h00, {7'h0, host_mode_o});
   endtask
   // Internal execution, then external fetch, then latch strobe off
   task automatic t_fetch();
      logic [7:0] ps, al, rd, wr;
      set_req(1'b0, ebp_pkg::EBP_DM_NONE, 1'b0, 8'h00);
      window(ps, al, rd, wr);
      check("ps_int", 8'h00, ps);
      check("ale_int", 8'h04, al);
      set_req(1'b1, ebp_pkg::EBP_DM_NONE, 1'b0, 8'h5a);
      window(ps, al, rd, wr);
      check("ps_ext", 8'h0c, ps);
      check("ale_ext", 8'h04, al);
      check("hi_addr", 8'h5a, hi_pin);
      check("rd_idle", 8'h00, rd);
      ale_off = 1'b1;
      window(ps, al, rd, wr);
      check("ale_off", 8'h00, al);
      ale_off = 1'b0;
   endtask
   // Wide data read and write, then short-pointer write: strobes, skipped pulses, address byte
   task automatic t_data();
      logic [7:0] ps, al, rd, wr;
      set_req(1'b1, ebp_pkg::EBP_DM_READ, 1'b1, 8'h3c);
      window(ps, al, rd, wr);
      check("ps_rd", 8'h06, ps);
      check("ale_rd", 8'h02, al);
      check("rd_lo", 8'h10, rd);
      check("wr_lo_rd", 8'h00, wr);
      check("hi_addr_rd", 8'h3c, hi_pin);
      set_req(1'b1, ebp_pkg::EBP_DM_WRITE, 1'b1, 8'hc3);
      window(ps, al, rd, wr);
      check("ps_wr", 8'h06, ps);
      check("wr_lo", 8'h10, wr);
      check("rd_lo_wr", 8'h00, rd);
      check("hi_addr_wr", 8'hc3, hi_pin);
      // Wide read while executing internally: address byte, no store strobe
      set_req(1'b0, ebp_pkg::EBP_DM_READ, 1'b1, 8'ha5);
      window(ps, al, rd, wr);
      check("ps_int_rd", 8'h00, ps);
      check("ale_int_rd", 8'h02, al);
      check("rd_int", 8'h10, rd);
      check("hi_addr_int", 8'ha5, hi_pin);
      // Short-pointer write while executing internally: port keeps its latch
      set_req(1'b0, ebp_pkg::EBP_DM_WRITE, 1'b0, 8'h77);
      window(ps, al, rd, wr);
      check("wr_int", 8'h10, wr);
      check("hi_no_addr", 8'hff, hi_pin);
      set_req(1'b0, ebp_pkg::EBP_DM_NONE, 1'b0, 8'h00);
   endtask
   // Port latches, pull-up reads and alternate functions
   task automatic t_pins();
      hi_d = 8'h00;
      hi_we = 1'b1;
      @(negedge ref_clk_i);
      hi_we = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      check("hi_drive0", 8'h00, hi_rd);
      hi_d = 8'hff;
      hi_we = 1'b1;
      hi_low = 8'h0f;
      mf_low = 8'h3d;
      @(negedge ref_clk_i);
      hi_we = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      check("hi_input", 8'hf0, hi_rd);
      check("mf_input", 8'hc2, mf_rd);
      check("alt_in_low", 8'h00, {3'h0, alt_in});
      hi_low = 8'h00;
      mf_low = 8'h00;
      alt_out.txd = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      check("alt_in_high", 8'h1f, {3'h0, alt_in});
      check("txd_low", 8'h00, {7'h0, mf_pin[1]});
      alt_out.txd = 1'b1;
      mf_d = 8'hfd;
      mf_we = 1'b1;
      @(negedge ref_clk_i);
      mf_we = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      check("txd_latch0", 8'h00, {7'h0, mf_pin[1]});
      mf_d = 8'hff;
      mf_we = 1'b1;
      @(negedge ref_clk_i);
      mf_we = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      check("txd_high", 8'h01, {7'h0, mf_pin[1]});
   endtask
   // Strobe forced low under a held reset pin of a given length
   task automatic t_host(input int mcs, input logic exp);
      rst_pin_i = 1'b1;
      repeat (12 * mcs) @(negedge ref_clk_i);
      check("ps_released", 8'h01, {7'h0, ps_oe_n});
      ps_force = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      check("host_entry", {7'h0, exp}, {7'h0, host_mode_o});
      ps_force = 1'b0;
      rst_pin_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
   endtask
   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      repeat (20) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      rst_pin_i = 1'b1;
      repeat (24) @(negedge ref_clk_i);
      rst_pin_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      t_reset();
      t_fetch();
      t_data();
      t_pins();
      t_host(10, 1'b0);
      t_host(20, 1'b0);
      t_host(22, 1'b1);
      reset_n_i = 1'b0;
      repeat (20) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      @(negedge ref_clk_i);
      check("host_cleared", 8'h00, {7'h0, host_mode_o});
      give_verdict();
   end
endmodule // ebp_port_pins_tb
`default_nettype wire
